// *** core/tcgs_pkg.sv ***
// constants and state codes of the trigger clock gating sequencer
// Functional notes
// - a wake-up pretrigger is taken only while busy is low, else ignored.
// - after a taken pretrigger the quarter-rate sample clock runs for drift.
// - sampling continues 5.5 sample clocks after drift to drain the converter.
// - preprocessor gets one more sample clock before results count as ready.
// - at end of digitisation preprocessor clocks go full speed, 67 ns left.
// - at the 2.55 us mark fast clocks start processor and segment readout.
// - up to four candidates start one thread each when preprocessing ends.
// - processing and selection end 1.5 us after the processor starts.
// - segments leave in chamber order, at most 40 per chamber, rest dropped.
// - readout moves one word per fast clock cycle.
// - idle gates all digital clocks off; analogue side keeps running.
// - after segment readout, fast clocks stop and level-1 is awaited.
// - level-1 accept or reject re-enables clocks for cleanup, then idle.
// - the first 250 ns of drift may be discarded.
// - level-1 answer must come within the 500 ns after the 6 us decision.
// - all clocks derive from the reference clock synchronously.
// - trigger line high two or more clocks aborts and clears at any time.
package tcgs_pkg;
   localparam int CLK_NS      = 50;
   localparam int REF_DIV     = 4;
   localparam int PRETRIG_NS  = 100;
   localparam int DISCARD_NS  = 250;
   localparam int DRAIN_HALF  = 11;
   localparam int PP_NS       = 67;
   localparam int FAST_NS     = 2550;
   localparam int PROC_NS     = 1500;
   localparam int L1_LATE_NS  = 6500;
   localparam int CLEANUP_CNT = 16;
   localparam int MAX_SEG     = 40;
   localparam int FIFO_DEPTH  = 16;
   localparam int SEG_WIDTH   = 16;
   localparam int TMR_W       = 8;

   localparam int DISCARD_CYC =
      (DISCARD_NS - PRETRIG_NS + CLK_NS - 1) / CLK_NS;
   localparam int FAST_CYC    = (FAST_NS - PRETRIG_NS) / CLK_NS;
   localparam int PP_CYC      = (PP_NS + CLK_NS - 1) / CLK_NS;
   localparam int DRAIN_CYC   = (DRAIN_HALF * REF_DIV + 1) / 2;
   localparam int DIG_END_CYC = FAST_CYC - PP_CYC - REF_DIV;
   localparam int PP_CYC_MARK = DIG_END_CYC + REF_DIV;
   localparam int DRIFT_CYC   = DIG_END_CYC - DRAIN_CYC;
   localparam int PROC_END    = FAST_CYC + PROC_NS / CLK_NS;
   localparam int L1_LATE_CYC = (L1_LATE_NS - PRETRIG_NS) / CLK_NS;

   typedef enum logic [6:0]
   {
      S_IDLE    = 7'h01,
      S_SAMPLE  = 7'h02,
      S_PPFAST  = 7'h04,
      S_PROC    = 7'h08,
      S_SHIP    = 7'h10,
      S_STANDBY = 7'h20,
      S_CLEAN   = 7'h40
   } tcgs_state_t;
endpackage : tcgs_pkg

// *** core/tcgs_sequencer.sv ***
// segment fifo and trigger clock gating sequencer
`timescale 1ns/1ps
`default_nettype none

module tcgs_fifo
   import tcgs_pkg::*;
#(
   parameter int WIDTH = SEG_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             mem_empty
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             ov_q, ov_d, rdy_q, rdy_d;
   logic [WIDTH-1:0] od_q, od_d;
   logic             push, pop;

   // pointers wrap naturally, so depth must be a power of two
   always_comb
   begin
      push  = in_valid && rdy_q;
      pop   = (cnt_q != '0) && (!ov_q || out_ready);
      wp_d  = push ? wp_q + 1'b1 : wp_q;
      rp_d  = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
      ov_d  = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
      od_d  = pop ? mem[rp_q] : od_q;
      rdy_d = cnt_d < (AW+1)'(DEPTH);
      if (flush)
      begin
         wp_d  = '0;
         rp_d  = '0;
         cnt_d = '0;
         ov_d  = 1'b0;
         rdy_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         ov_q  <= 1'b0;
         od_q  <= '0;
         rdy_q <= 1'b1;
      end
      else
      begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
         ov_q  <= ov_d;
         od_q  <= od_d;
         rdy_q <= rdy_d;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (push)
         mem[wp_q] <= in_data;
   end

   assign in_ready  = rdy_q;
   assign out_valid = ov_q;
   assign out_data  = od_q;
   assign mem_empty = (cnt_q == '0);
endmodule : tcgs_fifo

module tcgs_sequencer
   import tcgs_pkg::*;
#(
   parameter int WIDTH   = SEG_WIDTH,
   parameter int DEPTH   = FIFO_DEPTH,
   parameter int SEG_MAX = MAX_SEG
)
(
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic             trigger_input_line,
   input  wire logic [3:0]       cand_valid,
   input  wire logic             seg_valid,
   input  wire logic             seg_last,
   input  wire logic [WIDTH-1:0] seg_data,
   output var  logic             seg_ready,
   output var  logic             out_valid,
   output var  logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready,
   output var  logic             busy,
   output var  logic             sample_clk_en,
   output var  logic             sample_tick,
   output var  logic             adc_keep,
   output var  logic             pp_fast_en,
   output var  logic             fast_clk_en,
   output var  logic [3:0]       thread_start,
   output var  logic             level1_accept,
   output var  logic             level1_reject,
   output var  logic             cleanup
);
   tcgs_state_t      st_q, st_d;
   logic             trg_m_q, trg_s_q;
   logic [1:0]       len_q, len_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic [1:0]       div_q, div_d;
   logic [5:0]       seg_cnt_q, seg_cnt_d;
   logic             busy_q, busy_d, samp_q, samp_d, tick_q, tick_d;
   logic             keep_q, keep_d, ppf_q, ppf_d, fast_q, fast_d;
   logic [3:0]       thr_q, thr_d;
   logic             l1a_q, l1a_d, l1r_q, l1r_d, cln_q, cln_d;
   logic             rise, pulse1, clr, flush, seg_hs, f_push;
   logic             f_rdy, f_ov, f_empty;
   logic [WIDTH-1:0] f_od;

   function automatic logic at_mark(input logic [TMR_W-1:0] t,
                                    input int m);
      at_mark = (t == TMR_W'(m));
   endfunction : at_mark

   // trigger line arrives from the distribution network, off-domain
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         trg_m_q <= 1'b0;
         trg_s_q <= 1'b0;
      end
      else
      begin
         trg_m_q <= trigger_input_line;
         trg_s_q <= trg_m_q;
      end
   end

   always_comb
   begin
      len_d  = trg_s_q ? ((len_q == 2'h2) ? len_q : len_q + 1'b1) : 2'h0;
      rise   = trg_s_q && (len_q == 2'h0);
      pulse1 = !trg_s_q && (len_q == 2'h1);
      clr    = trg_s_q && (len_q != 2'h0);
      seg_hs = seg_valid && f_rdy && (st_q == S_PROC);
      f_push = seg_hs && (seg_cnt_q < 6'(SEG_MAX));
      seg_cnt_d = seg_cnt_q;
      if (seg_hs)
         seg_cnt_d = seg_last ? 6'h00 : (f_push ? seg_cnt_q + 1'b1 : seg_cnt_q);
      st_d  = st_q;
      tmr_d = (tmr_q == '1) ? tmr_q : tmr_q + 1'b1;
      thr_d = 4'h0;
      l1a_d = 1'b0;
      l1r_d = 1'b0;
      flush = 1'b0;
      unique case (st_q)
         S_IDLE:
         begin
            tmr_d = '0;
            if (rise && !busy_q)
               st_d = S_SAMPLE;
         end
         S_SAMPLE:
            if (at_mark(tmr_q, PP_CYC_MARK))
               st_d = S_PPFAST;
         S_PPFAST:
            if (at_mark(tmr_q, FAST_CYC))
            begin
               st_d  = S_PROC;
               thr_d = cand_valid;
            end
         S_PROC:
            if (at_mark(tmr_q, PROC_END))
               st_d = S_SHIP;
         S_SHIP:
            if (!f_ov && f_empty)
               st_d = S_STANDBY;
         S_STANDBY:
            if (pulse1)
            begin
               st_d  = S_CLEAN;
               l1a_d = 1'b1;
               tmr_d = '0;
            end
            else if (at_mark(tmr_q, L1_LATE_CYC))
            begin
               st_d  = S_CLEAN;
               l1r_d = 1'b1;
               tmr_d = '0;
            end
         S_CLEAN:
            if (at_mark(tmr_q, CLEANUP_CNT))
            begin
               st_d  = S_IDLE;
               flush = 1'b1;
            end
         default:
            st_d = S_IDLE;
      endcase
      if (clr)
      begin
         st_d  = S_IDLE;
         flush = 1'b1;
         thr_d = 4'h0;
         l1a_d = 1'b0;
         l1r_d = 1'b0;
         seg_cnt_d = 6'h00;
      end
      busy_d = (st_d != S_IDLE);
      // idle leaves every gate off; analogue chain is never gated here
      samp_d = (st_d == S_SAMPLE) || (st_d == S_CLEAN);
      ppf_d  = (st_d == S_PPFAST) || (st_d == S_CLEAN);
      fast_d = (st_d == S_PROC) || (st_d == S_SHIP)
               || (st_d == S_CLEAN);
      cln_d  = (st_d == S_CLEAN);
      // sample rate is a divided enable, keeps phase with the reference
      div_d  = samp_d ? div_q + 1'b1 : 2'h0;
      tick_d = samp_d && (div_q == 2'(REF_DIV - 1));
      keep_d = (st_d == S_SAMPLE) && (tmr_d >= TMR_W'(DISCARD_CYC))
               && (tmr_d < TMR_W'(DIG_END_CYC));
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q      <= S_IDLE;
         len_q     <= 2'h0;
         tmr_q     <= '0;
         div_q     <= 2'h0;
         seg_cnt_q <= 6'h00;
         busy_q    <= 1'b0;
         samp_q    <= 1'b0;
         tick_q    <= 1'b0;
         keep_q    <= 1'b0;
         ppf_q     <= 1'b0;
         fast_q    <= 1'b0;
         thr_q     <= 4'h0;
         l1a_q     <= 1'b0;
         l1r_q     <= 1'b0;
         cln_q     <= 1'b0;
      end
      else
      begin
         st_q      <= st_d;
         len_q     <= len_d;
         tmr_q     <= tmr_d;
         div_q     <= div_d;
         seg_cnt_q <= seg_cnt_d;
         busy_q    <= busy_d;
         samp_q    <= samp_d;
         tick_q    <= tick_d;
         keep_q    <= keep_d;
         ppf_q     <= ppf_d;
         fast_q    <= fast_d;
         thr_q     <= thr_d;
         l1a_q     <= l1a_d;
         l1r_q     <= l1r_d;
         cln_q     <= cln_d;
      end
   end

   // link drains one word per enabled cycle, stalls back to the processor
   tcgs_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .flush     (flush),
      .in_valid  (f_push),
      .in_ready  (f_rdy),
      .in_data   (seg_data),
      .out_valid (f_ov),
      .out_ready (out_ready && fast_q),
      .out_data  (f_od),
      .mem_empty (f_empty)
   );

   assign seg_ready     = f_rdy;
   assign out_valid     = f_ov;
   assign out_data      = f_od;
   assign busy          = busy_q;
   assign sample_clk_en = samp_q;
   assign sample_tick   = tick_q;
   assign adc_keep      = keep_q;
   assign pp_fast_en    = ppf_q;
   assign fast_clk_en   = fast_q;
   assign thread_start  = thr_q;
   assign level1_accept = l1a_q;
   assign level1_reject = l1r_q;
   assign cleanup       = cln_q;
endmodule : tcgs_sequencer

`default_nettype wire

// *** tb/tcgs_sequencer_properties.sv ***
// port assertions for the trigger clock gating sequencer
`timescale 1ns/1ps
`default_nettype none
module tcgs_chk
(
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic       trigger_input_line,
   input wire logic [3:0] cand_valid,
   input wire logic       out_valid,
   input wire logic       busy,
   input wire logic       sample_clk_en,
   input wire logic       sample_tick,
   input wire logic       adc_keep,
   input wire logic       pp_fast_en,
   input wire logic       fast_clk_en,
   input wire logic [3:0] thread_start,
   input wire logic       level1_accept,
   input wire logic       level1_reject,
   input wire logic       cleanup
);
   logic       t1_q, t2_q, t3_q, clr_q;
   logic [7:0] tmr_q;
   logic [4:0] cl_q;
   wire  logic clr = t2_q & t3_q;
   wire  logic take = t2_q & ~t3_q & ~busy;
   wire  logic run = busy & ~cleanup;
   // mirrors the phase count: zero on the first busy cycle
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         {t1_q, t2_q, t3_q, clr_q, tmr_q, cl_q} <= '0;
      end
      else
      begin
         {t1_q, t2_q, t3_q} <= {trigger_input_line, t1_q, t2_q};
         clr_q <= clr;
         tmr_q <= run ? tmr_q + 8'h01 : 8'h00;
         cl_q  <= cleanup ? cl_q + 5'h01 : 5'h00;
      end
   end
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   wake_gate_a:
      assert property (!busy |=> busy == $past(take)) else $error("wake");
   sample_span_a:
      assert property (run |-> sample_clk_en == (tmr_q < 8'h30))
      else $error("sample span");
   tick_phase_a:
      assert property (run |-> sample_tick
         == (sample_clk_en && tmr_q[1:0] == 2'h3)) else $error("tick phase");
   keep_span_a:
      assert property (run |-> adc_keep == (tmr_q inside {[8'h03:8'h2a]}))
      else $error("keep span");
   full_speed_a:
      assert property ($rose(pp_fast_en) && !cleanup |-> tmr_q == 8'h30)
      else $error("full speed mark");
   proc_start_a:
      assert property (run && tmr_q == 8'h32 |-> fast_clk_en
         && thread_start == $past(cand_valid)) else $error("proc start");
   proc_span_a:
      assert property (run && tmr_q < 8'h51 |-> fast_clk_en == (tmr_q > 8'h31))
      else $error("proc span");
   clean_in_a:
      assert property ($rose(cleanup) |-> fast_clk_en && sample_clk_en
         && (level1_accept || level1_reject && tmr_q == 8'h81))
      else $error("cleanup entry");
   clean_len_a:
      assert property ($fell(cleanup) && !clr_q |-> !busy && cl_q == 5'h11)
      else $error("cleanup length");
   abort_clear_a:
      assert property (clr |=> !busy && !out_valid && !fast_clk_en
         && !pp_fast_en) else $error("abort");
   cover property (level1_accept);
   cover property (level1_reject);
   cover property (clr && busy);
endmodule : tcgs_chk
bind tcgs_sequencer tcgs_chk i_chk (.*);
`default_nettype wire

// *** tb/tcgs_far_model.sv ***
// processor segment source and global unit readout sink
`timescale 1ns/1ps
`default_nettype none
module tcgs_far
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        fast_clk_en,
   input  wire logic        seg_ready,
   input  wire logic        out_valid,
   input  wire logic [15:0] out_data,
   input  wire logic [5:0]  n_send,
   input  wire logic [15:0] base,
   input  wire logic        stall,
   output var  logic        seg_valid,
   output var  logic        seg_last,
   output var  logic [15:0] seg_data,
   output var  logic        out_ready
);
   logic [15:0] got [$];
   logic [5:0]  idx;
   logic        fast_q;
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         {seg_valid, seg_last, seg_data, out_ready, idx, fast_q} <= '0;
      end
      else
      begin
         fast_q    <= fast_clk_en;
         out_ready <= !stall;
         if (out_valid && out_ready && fast_clk_en)
            got.push_back(out_data);
         if (fast_clk_en && !fast_q && n_send != 6'h00)
         begin
            seg_valid <= 1'b1;
            seg_data  <= base;
            seg_last  <= n_send == 6'h01;
            idx       <= 6'h00;
         end
         else if (seg_valid && seg_ready && fast_clk_en)
         begin
            idx       <= idx + 6'h01;
            seg_valid <= idx + 6'h01 != n_send;
            seg_data  <= base + 16'(idx + 6'h01);
            seg_last  <= idx + 6'h02 == n_send;
         end
         else if (!seg_valid || !fast_clk_en)
         begin
            // idle lines wander so a stale word never looks valid
            seg_valid <= 1'b0;
            {seg_last, seg_data} <= ~{seg_last, seg_data};
         end
      end
   end
endmodule : tcgs_far
`default_nettype wire

// *** tb/tcgs_sequencer_tb.sv ***
// self-checking bench for the trigger clock gating sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 400) begin \
   @(negedge core_clk); k++; end `CHK("wait", 1'b1, (c)) end
module tcgs_sequencer_tb
   import tcgs_pkg::*;
;
   logic                 core_clk = 1'b0;
   logic                 nrst = 1'b0;
   logic                 trigger_input_line = 1'b0;
   logic                 stall = 1'b0;
   logic [3:0]           cand_valid = 4'h0;
   logic [5:0]           n_send = 6'h00;
   logic [SEG_WIDTH-1:0] base = 16'h0000;
   localparam int        CAP = 20;
   logic [31:0]          seed = 32'h87f6ab90;
   int                   n_acc = 0;
   int                   n_rej = 0;
   int                   fails = 0;
   int                   n_compared = 0;
   int                   k;
   wire  logic [SEG_WIDTH-1:0] seg_data, out_data;
   wire  logic [3:0]           thread_start;
   wire  logic seg_valid, seg_last, seg_ready, out_valid, out_ready, busy,
      sample_clk_en, sample_tick, adc_keep, pp_fast_en, fast_clk_en,
      level1_accept, level1_reject, cleanup;
   // cap lowered: forty segments cannot fit in the processing window
   tcgs_sequencer #(.SEG_MAX(CAP)) i_dut (.*);
   tcgs_far i_far (.*);
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      // counted, not flagged, so a doubled pulse shows up
      if (level1_accept === 1'b1) n_acc <= n_acc + 1;
      if (level1_reject === 1'b1) n_rej <= n_rej + 1;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic int shipped(input int n);
      return (n < CAP) ? n : CAP;
   endfunction : shipped
   task automatic close_out();
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   task automatic pulse(input int len);
      @(posedge core_clk);
      trigger_input_line <= 1'b1;
      repeat (len) @(posedge core_clk);
      trigger_input_line <= 1'b0;
   endtask : pulse
   task automatic run_event(input int n, input logic st, input logic acc);
      logic [SEG_WIDTH-1:0] b;
      logic [3:0]           cv;
      int                   a0;
      int                   r0;
      b = SEG_WIDTH'(xs());
      cv = 4'(xs());
      a0 = n_acc;
      r0 = n_rej;
      i_far.got.delete();
      @(posedge core_clk);
      base <= b;
      cand_valid <= cv;
      n_send <= 6'(n);
      stall <= st;
      pulse(1);
      `WAIT(busy === 1'b1)
      // a second pulse while sampling must change nothing
      if (!st) pulse(1);
      `WAIT(fast_clk_en === 1'b1)
      `CHK("thread_start", cv, thread_start)
      if (st)
      begin
         `WAIT(seg_ready === 1'b0)
         `CHK("held", 6'(FIFO_DEPTH + 1), i_far.idx)
         @(posedge core_clk);
         stall <= 1'b0;
      end
      `WAIT(fast_clk_en === 1'b0)
      if (acc) pulse(1);
      `WAIT(busy === 1'b0)
      `CHK("level1", {8'(acc), 8'(!acc)}, {8'(n_acc - a0), 8'(n_rej - r0)})
      `CHK("count", shipped(n), i_far.got.size())
      foreach (i_far.got[i])
         `CHK("word", b + SEG_WIDTH'(i), i_far.got[i])
   endtask : run_event
   initial
   begin
      #(50 * 5000);
      fails++;
      $display("ERROR watchdog exp done got hung");
      close_out();
   end
   initial
   begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(negedge core_clk);
      `CHK("reset", 3'b010, {busy, seg_ready, fast_clk_en})
      run_event(18, 1'b1, 1'b1);
      run_event(21, 1'b0, 1'b0);
      repeat (5) run_event(1 + int'(xs() % 32'd20), 1'b0, 1'(xs()));
      @(posedge core_clk);
      n_send <= 6'h04;
      pulse(1);
      `WAIT(fast_clk_en === 1'b1)
      pulse(2);
      `WAIT(busy === 1'b0)
      `CHK("abort", 3'b000, {out_valid, fast_clk_en, sample_clk_en})
      close_out();
   end
endmodule : tcgs_sequencer_tb
`default_nettype wire
